/* design/fesc_pkg.sv */
// Constants shared by the front-panel frequency control block.
// Assumes a 100 MHz aclk and frequencies held as whole hertz.
`default_nettype none
package fesc_pkg;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned MS_CYC       = CLK_HZ / 1000;
  localparam int unsigned FLASH_MS     = 100;
  localparam int unsigned FLASH_CYC_DF = FLASH_MS * MS_CYC;
  localparam int unsigned STEP_FAST_MS = 1;
  localparam int unsigned STEP_SLOW_MS = 50;
  localparam int unsigned STEP1_CYC_DF = STEP_FAST_MS * MS_CYC;
  localparam int unsigned STEP50_CYC_DF = STEP_SLOW_MS * MS_CYC;
  localparam logic [9:0]  SWEEP_N_FAST = 10'h064;   // 100 points
  localparam logic [9:0]  SWEEP_N_LONG = 10'h3e8;   // 1000 points
  // ****************************************************
  // Frequencies in hertz
  // ****************************************************
  localparam logic [31:0] CENTER_RST = 32'h000f4240; // 1 MHz
  localparam logic [31:0] LOW_RST    = 32'h000f4240; // 1 MHz
  localparam logic [31:0] UP_RST     = 32'h068e777f; // 109.999999 MHz
  localparam logic [31:0] INC_FINE   = 32'h00000001;
  localparam logic [31:0] INC_MED    = 32'h000003e8;
  localparam logic [31:0] INC_COARSE = 32'h000f4240;
  localparam logic [3:0]  MAX_DIGITS = 4'h9;
  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFF_KEY    = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_ENTRY  = 8'h08;
  localparam logic [7:0] OFF_CENTER = 8'h0c;
  localparam logic [7:0] OFF_STEP   = 8'h10;
  localparam logic [7:0] OFF_SPAN   = 8'h14;
  localparam logic [7:0] OFF_OUT    = 8'h18;
  localparam logic [7:0] OFF_SHOW   = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_ISTAT  = 8'h24;
  localparam logic [7:0] OFF_IMASK  = 8'h28;
  localparam logic [7:0] OFF_LOW    = 8'h2c;
  localparam logic [7:0] OFF_UP     = 8'h30;
  // CTRL fields: [1:0] resolution, [3:2] sweep mode, [5:4] rate,
  // [7:6] readout select, [8] standby
  localparam int CTRL_RES = 0;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_RATE = 4;
  localparam int CTRL_DISP = 6;
  localparam int CTRL_STBY = 8;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [1:0] RES_FINE = 2'h0, RES_MED = 2'h1, RES_COARSE = 2'h2;
  localparam logic [1:0] RES_STEP = 2'h3;
  localparam logic [1:0] MODE_OFF = 2'h0, MODE_AUTO = 2'h1, MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_HAND = 2'h3;
  localparam logic [1:0] RATE_FAST = 2'h0, RATE_MED = 2'h1, RATE_SLOW = 2'h2;
  localparam logic [1:0] DISP_CENTER = 2'h0, DISP_ENTRY = 2'h1;
  localparam logic [1:0] DISP_STEP = 2'h2, DISP_SPAN = 2'h3;
  // Interrupt bits: [0] out-of-range reject, [1] single sweep done
  localparam int IRQ_W = 2;
  // Key codes written to KEY[4:0]; 0 to 9 are digits
  localparam logic [4:0] KEY_POINT = 5'h0a, KEY_CLEAR = 5'h0b;
  localparam logic [4:0] KEY_HZ = 5'h0c, KEY_KHZ = 5'h0d, KEY_MHZ = 5'h0e;
  localparam logic [4:0] KEY_GHZ = 5'h0f, KEY_CENTER = 5'h10;
  localparam logic [4:0] KEY_UP = 5'h11, KEY_DOWN = 5'h12;
  localparam logic [4:0] KEY_SPAN = 5'h13, KEY_SINGLE = 5'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
  typedef enum logic {SW_IDLE, SW_RUN} fesc_sweep_e;
endpackage
`default_nettype wire

/* design/fesc_top.sv */
// Front-panel frequency entry, stepping, tuning and sweep control.
// Assumes an AXI4-Lite master for keys and settings, and an encoder
// that gives one pulse per detent on asynchronous cw and ccw pins.
// Summary of operation
// - After reset centre frequency and readout hold one megahertz.
// - Up to nine entered digits shift into the entry from the right.
// - A unit key rescales the entry from that unit to hertz, truncating lower digits.
// - Clear key zeroes the entry, its digit count and fraction, not the centre.
// - Step-up adds the step register to the centre frequency.
// - Encoder ccw detent in step resolution subtracts the step value.
// - Encoder cw detent adds 1 MHz, 1 kHz or 1 Hz by resolution.
// - A request above the upper limit flashes the range lamp.
// - An over-range request is rejected; centre keeps last valid value.
// - Centre below the lower limit keeps the range lamp lit.
// - Step display selects the step register onto the readout.
// - Hand sweep tunes within centre plus or minus half the span.
// - Single key in single mode sweeps once across the span.
// - Auto sweep stays centred on a changed centre, span unchanged.
// - Auto sweep lights sweep lamp; range lamp follows swept limits.
// - Rates: fast 100x1 ms, medium 1000x1 ms, slow 1000x50 ms.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`default_nettype none
module fesc_top
  import fesc_pkg::*;
#(
  parameter int unsigned FLASH_CYC  = FLASH_CYC_DF,
  parameter int unsigned STEP1_CYC  = STEP1_CYC_DF,
  parameter int unsigned STEP50_CYC = STEP50_CYC_DF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tune_cw,
  input  wire logic        tune_ccw,
  output logic [31:0]      readout_hz,
  output logic [31:0]      out_freq_hz,
  output logic             range_violation_lamp,
  output logic             sweep_lamp,
  output logic             irq
);
  // ****************************************************
  // Functions
  // ****************************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFF_UP);
  endfunction

  function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
    strb = o;
  endfunction

  function automatic logic [63:0] pow10(input logic [3:0] e);
    pow10 = 64'h1;
    for (int i = 0; i < 9; i++) begin
      if (i < e) pow10 = pow10 * 64'ha;
    end
  endfunction

  // ****************************************************
  // Encoder pins: two-stage synchronisers, then edge detect
  // ****************************************************
  logic [1:0] cw_sync_q, ccw_sync_q;
  logic       cw_old_q, ccw_old_q;
  logic       cw_ev, ccw_ev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cw_sync_q  <= 2'h0;
      ccw_sync_q <= 2'h0;
      cw_old_q   <= 1'b0;
      ccw_old_q  <= 1'b0;
    end else begin
      cw_sync_q  <= {cw_sync_q[0], tune_cw};
      ccw_sync_q <= {ccw_sync_q[0], tune_ccw};
      cw_old_q   <= cw_sync_q[1];
      ccw_old_q  <= ccw_sync_q[1];
    end
  end
  assign cw_ev  = cw_sync_q[1] & ~cw_old_q;
  assign ccw_ev = ccw_sync_q[1] & ~ccw_old_q;

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        wr_go;
  logic [31:0] ctrl_q, ctrl_d, low_q, low_d, up_q, up_d;
  logic [IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d, ev;
  logic [31:0] center_q, step_q, span_q, entry_q, out_q, show_q;
  logic [3:0]  frac_q;
  logic        lamp_q, slamp_q;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;

  // Write address and data are caught separately; the write lands once both are held
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    low_d     = low_q;
    up_d      = up_q;
    imask_d   = imask_q;
    istat_d   = istat_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr_q == OFF_CTRL) begin
        ctrl_d = strb(ctrl_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == OFF_IMASK) begin
        imask_d = IRQ_W'(strb({30'h0, imask_q}, w_data_q, w_strb_q));
      end else if (aw_addr_q == OFF_LOW) begin
        low_d = strb(low_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == OFF_UP) begin
        up_d = strb(up_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == OFF_ISTAT && w_strb_q[0]) begin
        istat_d = istat_q & ~w_data_q[IRQ_W-1:0];
      end
    end
    // A new event wins over a clear in the same cycle
    istat_d = istat_d | ev;
    if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFF_CTRL) rdata_d = ctrl_q;
      else if (s_axi_araddr == OFF_ENTRY) rdata_d = entry_q;
      else if (s_axi_araddr == OFF_CENTER) rdata_d = center_q;
      else if (s_axi_araddr == OFF_STEP) rdata_d = step_q;
      else if (s_axi_araddr == OFF_SPAN) rdata_d = span_q;
      else if (s_axi_araddr == OFF_OUT) rdata_d = out_q;
      else if (s_axi_araddr == OFF_SHOW) rdata_d = show_q;
      else if (s_axi_araddr == OFF_STATUS) rdata_d = {26'h0, frac_q, slamp_q, lamp_q};
      else if (s_axi_araddr == OFF_ISTAT) rdata_d = {30'h0, istat_q};
      else if (s_axi_araddr == OFF_IMASK) rdata_d = {30'h0, imask_q};
      else if (s_axi_araddr == OFF_LOW) rdata_d = low_q;
      else if (s_axi_araddr == OFF_UP) rdata_d = up_q;
      else rdata_d = 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
      ctrl_q    <= CTRL_RST;
      low_q     <= LOW_RST;
      up_q      <= UP_RST;
      imask_q   <= '0;
      istat_q   <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      low_q     <= low_d;
      up_q      <= up_d;
      imask_q   <= imask_d;
      istat_q   <= istat_d;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ****************************************************
  // Entry, centre, step and span registers
  // ****************************************************
  logic [1:0]  res, mode, rate;
  logic        key_ok;
  logic [4:0]  key;
  logic [31:0] step_d, span_d, center_d, entry_d, inc;
  logic [3:0]  frac_d, ndig_q, ndig_d;
  logic        point_q, point_d, done_q, done_d, fresh_q, fresh_d;
  logic [23:0] flash_q, flash_d;
  logic signed [33:0] hoff_q, hoff_d, cand, half;
  logic        take, rej;
  logic [63:0] scaled;
  logic [3:0]  uexp;
  assign res    = ctrl_q[CTRL_RES +: 2];
  assign mode   = ctrl_q[CTRL_MODE +: 2];
  assign rate   = ctrl_q[CTRL_RATE +: 2];
  assign key_ok = wr_go && aw_addr_q == OFF_KEY && w_strb_q[0];
  assign key    = w_data_q[4:0];
  assign half   = 34'(span_q >> 1);

  // Keys take priority over an encoder detent in the same cycle
  always_comb begin
    entry_d  = entry_q;
    frac_d   = frac_q;
    ndig_d   = ndig_q;
    point_d  = point_q;
    done_d   = done_q;
    fresh_d  = fresh_q;
    step_d   = step_q;
    span_d   = span_q;
    center_d = center_q;
    hoff_d   = (mode == MODE_HAND) ? hoff_q : 34'sh0;
    take     = 1'b0;
    rej      = 1'b0;
    cand     = 34'sh0;
    uexp     = 4'h0;
    scaled   = 64'h0;
    inc      = (res == RES_COARSE) ? INC_COARSE :
               (res == RES_MED) ? INC_MED :
               (res == RES_STEP) ? step_q : INC_FINE;
    if (key_ok) begin
      if (key <= 5'h09) begin
        // A digit after a completed entry starts a new one
        if (done_q) begin
          entry_d = {28'h0, key[3:0]};
          frac_d  = 4'h0;
          ndig_d  = 4'h1;
          point_d = 1'b0;
          done_d  = 1'b0;
        end else if (ndig_q < MAX_DIGITS) begin
          entry_d = 32'(entry_q * 32'ha + {28'h0, key[3:0]});
          ndig_d  = ndig_q + 4'h1;
          frac_d  = point_q ? frac_q + 4'h1 : frac_q;
        end
      end else if (key == KEY_POINT) begin
        point_d = 1'b1;
      end else if (key == KEY_CLEAR) begin
        entry_d = 32'h0;
        frac_d  = 4'h0;
        ndig_d  = 4'h0;
        point_d = 1'b0;
        done_d  = 1'b0;
        fresh_d = 1'b0;
      end else if (key >= KEY_HZ && key <= KEY_GHZ) begin
        // Rescale to hertz; the integer divide drops the lower digits
        uexp   = 4'(3 * (key - KEY_HZ));
        scaled = ({32'h0, entry_q} * pow10(uexp)) / pow10(frac_q);
        entry_d = (scaled > 64'hffffffff) ? 32'hffffffff : scaled[31:0];
        frac_d  = uexp;
        done_d  = 1'b1;
        fresh_d = 1'b1;
      end else if (key == KEY_CENTER) begin
        cand    = {2'b0, entry_q};
        take    = 1'b1;
        fresh_d = 1'b0;
      end else if (key == KEY_UP || key == KEY_DOWN) begin
        // A fresh entry replaces the step, otherwise the old step is reused
        if (fresh_q) step_d = entry_q;
        fresh_d = 1'b0;
        cand = (key == KEY_UP) ? 34'(center_q) + 34'(step_d)
                               : 34'(center_q) - 34'(step_d);
        take = 1'b1;
      end else if (key == KEY_SPAN) begin
        span_d  = entry_q;
        fresh_d = 1'b0;
      end
    end else if (cw_ev ^ ccw_ev) begin
      if (mode == MODE_HAND) begin
        // Hand sweep moves in span/1000 steps, clamped to the span
        cand = 34'(span_q / 32'(SWEEP_N_LONG));
        hoff_d = cw_ev ? hoff_q + cand : hoff_q - cand;
        if (hoff_d > half) hoff_d = half;
        if (hoff_d < -half) hoff_d = -half;
        cand = 34'sh0;
      end else begin
        cand = cw_ev ? 34'(center_q) + 34'(inc)
                     : 34'(center_q) - 34'(inc);
        take = 1'b1;
      end
    end
    if (take) begin
      if (cand < 0 || cand > 34'(up_q)) rej = 1'b1;
      else center_d = cand[31:0];
    end
    if (ctrl_q[CTRL_STBY]) step_d = 32'h0;
    flash_d = rej ? 24'(FLASH_CYC) :
              (flash_q != 24'h0) ? flash_q - 24'h1 : 24'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_q  <= 32'h0;
      frac_q   <= 4'h0;
      ndig_q   <= 4'h0;
      point_q  <= 1'b0;
      done_q   <= 1'b0;
      fresh_q  <= 1'b0;
      step_q   <= 32'h0;
      span_q   <= 32'h0;
      center_q <= CENTER_RST;
      hoff_q   <= 34'sh0;
      flash_q  <= 24'h0;
    end else begin
      entry_q  <= entry_d;
      frac_q   <= frac_d;
      ndig_q   <= ndig_d;
      point_q  <= point_d;
      done_q   <= done_d;
      fresh_q  <= fresh_d;
      step_q   <= step_d;
      span_q   <= span_d;
      center_q <= center_d;
      hoff_q   <= hoff_d;
      flash_q  <= flash_d;
    end
  end

  // ****************************************************
  // Sweep engine and outputs
  // ****************************************************
  fesc_sweep_e sw_q, sw_d;
  logic [9:0]  idx_q, idx_d, npts;
  logic [22:0] tick_q, tick_d, tlim;
  logic        done_ev;
  logic signed [34:0] outv;
  logic [31:0] show_d;
  logic        lamp_d;

  assign npts = (rate == RATE_FAST) ? SWEEP_N_FAST : SWEEP_N_LONG;
  assign tlim = (rate == RATE_SLOW) ? 23'(STEP50_CYC - 1)
                                    : 23'(STEP1_CYC - 1);

  always_comb begin
    sw_d    = sw_q;
    idx_d   = idx_q;
    tick_d  = tick_q;
    done_ev = 1'b0;
    case (sw_q)
      SW_IDLE: begin
        idx_d  = 10'h0;
        tick_d = 23'h0;
        if (mode == MODE_AUTO) sw_d = SW_RUN;
        if (mode == MODE_SINGLE && key_ok && key == KEY_SINGLE) begin
          sw_d = SW_RUN;
        end
      end
      SW_RUN: begin
        if (mode != MODE_AUTO && mode != MODE_SINGLE) begin
          sw_d = SW_IDLE;
        end else if (tick_q >= tlim) begin
          tick_d = 23'h0;
          if (idx_q >= npts) begin
            idx_d = 10'h0;
            // Single sweep ends and the output returns to centre
            if (mode == MODE_SINGLE) begin
              sw_d    = SW_IDLE;
              done_ev = 1'b1;
            end
          end else begin
            idx_d = idx_q + 10'h1;
          end
        end else begin
          tick_d = tick_q + 23'h1;
        end
      end
      default: sw_d = SW_IDLE;
    endcase
    // Span is laid about the live centre, so stepping recentres it
    if (sw_q == SW_RUN) begin
      outv = 35'(center_q) - 35'(half) +
             35'((42'(span_q) * 42'(idx_q)) / 42'(npts));
    end else if (mode == MODE_HAND) begin
      outv = 35'(center_q) + 35'(hoff_q);
    end else begin
      outv = 35'(center_q);
    end
    lamp_d = (center_q < low_q) || (flash_q != 24'h0) ||
             (sw_q == SW_RUN && (outv < 35'(low_q) || outv > 35'(up_q)));
    case (ctrl_q[CTRL_DISP +: 2])
      DISP_ENTRY: show_d = entry_q;
      DISP_STEP:  show_d = step_q;
      DISP_SPAN:  show_d = span_q;
      default:    show_d = (mode == MODE_HAND) ? outv[31:0] : center_q;
    endcase
  end
  assign ev = {done_ev, rej};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q    <= SW_IDLE;
      idx_q   <= 10'h0;
      tick_q  <= 23'h0;
      out_q   <= CENTER_RST;
      show_q  <= CENTER_RST;
      lamp_q  <= 1'b0;
      slamp_q <= 1'b0;
      irq     <= 1'b0;
    end else begin
      sw_q    <= sw_d;
      idx_q   <= idx_d;
      tick_q  <= tick_d;
      out_q   <= (outv < 0) ? 32'h0 : outv[31:0];
      show_q  <= show_d;
      lamp_q  <= lamp_d;
      slamp_q <= (mode == MODE_AUTO);
      irq     <= |(istat_q & imask_q);
    end
  end
  assign readout_hz           = show_q;
  assign out_freq_hz          = out_q;
  assign range_violation_lamp = lamp_q;
  assign sweep_lamp           = slamp_q;
endmodule
`default_nettype wire

/* testbench/fesc_checker.sv */
// Port checker for the front-panel frequency control block.
// Assumes one aclk domain; bound to every fesc_top instance.
`default_nettype none
module fesc_checker
  import fesc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] readout_hz,
  input wire logic [31:0] out_freq_hz,
  input wire logic        range_violation_lamp,
  input wire logic        sweep_lamp,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  // Reset gates every check, one clock domain only
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_freq: assert property ($rose(aresetn) |->
    readout_hz == CENTER_RST && out_freq_hz == CENTER_RST) else $error("bad start freq");
  a_reset_lamps: assert property ($rose(aresetn) |->
    !range_violation_lamp && !sweep_lamp && !irq) else $error("lamps lit at start");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind fesc_top fesc_checker chk_u (.*);
`default_nettype wire

/* testbench/fesc_panel.sv */
// Rotary encoder model of the front panel.
// Assumes the bench calls detent; pins idle low between detents.
`default_nettype none
module fesc_panel (
  input  wire logic aclk,
  output logic      tune_cw,
  output logic      tune_ccw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {tune_cw, tune_ccw} = 2'h0;
  // One detent: pulse held 3 cycles, longer than the two-cycle minimum
  task automatic detent(input logic dir);
    @(posedge aclk);
    if (dir) tune_cw <= 1'b1;
    else tune_ccw <= 1'b1;
    repeat (3) @(posedge aclk);
    {tune_cw, tune_ccw} <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* testbench/fesc_top_tb.sv */
// Self-checking bench for the front-panel frequency control block.
// Assumes the panel model drives the encoder; the bench is AXI master.
`default_nettype none
module fesc_top_tb
  import fesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   range_violation_lamp, sweep_lamp, irq, tune_cw, tune_ccw;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, readout_hz, out_freq_hz;
  logic [33:0] q[$];
  logic [31:0] c, s;
  logic [31:0] inc [3] = '{INC_FINE, INC_MED, INC_COARSE};
  int          errors = 0, num_checks = 0, cyc = 0;
  // Short counts keep the flash and sweep timing quick to reach
  fesc_top #(.FLASH_CYC(20), .STEP1_CYC(4), .STEP50_CYC(8)) dut_u (.*);
  fesc_panel pan_u (.aclk(aclk), .tune_cw(tune_cw), .tune_ccw(tune_ccw));
  always #5 aclk = ~aclk;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [33:0] v, input logic [33:0] e);
    num_checks++;
    if (v !== e) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic flag(input logic v, input logic e);
    chk({33'h0, v}, {33'h0, e});
  endtask
  // Ready may come first for either channel, so each is released alone
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk); // Idle edge so the next call never re-raises bready in this step
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    q.push_back(e);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk); // Idle edge between reads
  endtask
  task automatic key(input logic [4:0] k);
    wr(OFF_KEY, {27'h0, k});
  endtask
  // Decimal digits, most significant first, closed by the hertz key
  task automatic ent(input logic [31:0] v);
    logic [31:0] p;
    p = 32'h1;
    while (p * 10 <= v) p = p * 10;
    while (p > 0) begin
      key(5'(v / p % 10));
      p = p / 10;
    end
    key(KEY_HZ);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read monitor takes the oldest note at each read handshake
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(32'h73d1));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk({2'h0, readout_hz}, {2'h0, CENTER_RST});
    rd(OFF_CENTER, {RESP_OKAY, CENTER_RST});
    key(5'h1);
    key(5'h2);
    rd(OFF_ENTRY, 34'h0c);
    key(KEY_KHZ);
    rd(OFF_ENTRY, 34'h2ee0);
    key(KEY_CLEAR);
    rd(OFF_ENTRY, 34'h0);
    rd(OFF_CENTER, {RESP_OKAY, CENTER_RST});
    $display("entry test done");
    s = $urandom % 200000 + 1;
    ent(s);
    key(KEY_UP);
    key(KEY_UP);
    c = CENTER_RST + s + s;
    rd(OFF_CENTER, {RESP_OKAY, c});
    rd(OFF_STEP, {RESP_OKAY, s});
    wr(OFF_CTRL, 32'h83);
    rd(OFF_SHOW, {RESP_OKAY, s});
    pan_u.detent(1'b0);
    c = c - s;
    rd(OFF_CENTER, {RESP_OKAY, c});
    for (int r = 0; r < 3; r++) begin
      wr(OFF_CTRL, 32'(r));
      pan_u.detent(1'b1);
      c = c + inc[r];
      rd(OFF_CENTER, {RESP_OKAY, c});
    end
    $display("step and tune test done");
    wr(OFF_UP, c);
    key(KEY_UP);
    repeat (3) @(posedge aclk);
    flag(range_violation_lamp, 1'b1);
    flag(irq, 1'b0);
    rd(OFF_CENTER, {RESP_OKAY, c});
    wr(OFF_IMASK, 32'h1);
    repeat (2) @(posedge aclk);
    flag(irq, 1'b1);
    wr(OFF_ISTAT, 32'h1);
    repeat (30) @(posedge aclk);
    flag(irq, 1'b0);
    flag(range_violation_lamp, 1'b0);
    wr(OFF_LOW, c + 1);
    repeat (30) @(posedge aclk);
    flag(range_violation_lamp, 1'b1);
    rd(8'h34, {RESP_SLVERR, 32'h0});
    $display("range test done");
    wr(OFF_CTRL, 32'h4);
    repeat (2) @(posedge aclk);
    flag(sweep_lamp, 1'b1);
    ent(2000);
    key(KEY_SPAN);
    key(KEY_DOWN);
    c = c - s;
    flag(out_freq_hz + 32'h3e8 - c <= 32'h7d0, 1'b1);
    s_axi_wstrb <= 4'h0;
    key(KEY_CLEAR);
    s_axi_wstrb <= 4'hf;
    rd(OFF_ENTRY, 34'h7d0);
    $display("sweep test done");
    wr(OFF_CTRL, 32'hc);
    pan_u.detent(1'b1);
    chk({2'h0, out_freq_hz}, {2'h0, c + 32'h2});
    wr(OFF_CTRL, 32'h8);
    key(KEY_SINGLE);
    repeat (300) @(posedge aclk);
    rd(OFF_ISTAT, 34'h0);
    repeat (200) @(posedge aclk);
    rd(OFF_ISTAT, 34'h2);
    chk({2'h0, out_freq_hz}, {2'h0, c});
    $display("hand and single sweep test done");
    test_done();
  end
endmodule
`default_nettype wire
